// >>> rtl/rtp_transceiver.sv
/*
 Sixteen-bit registered transceiver with byte parity, latch/clock data
 flow per direction, open-drain error flags and an AXI4-Lite register
 file with sticky error events and an interrupt.
 Assumes every pin input is asynchronous to clk; the transfer clocks are
 sampled, so they must stay well below half the clk rate.
*/
`timescale 1ns/1ns
module rtp_transceiver
   import rtp_pkg::*;
(
   // System
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // A-to-B controls
   input wire logic aToBOutputEnableN,
   input wire logic aToBLatchEnable,
   input wire logic aToBClock,
   input wire logic generateOrCheckSelect,
   // B-to-A controls
   input wire logic bToAOutputEnableN,
   input wire logic bToALatchEnable,
   input wire logic bToAClock,
   // Shared parity sense
   input wire logic paritySenseSelect,
   // A port data
   input wire logic [15:0] aPortDataIn,
   output logic [15:0] aPortDataOut,
   output logic aPortDataOe,
   // A port parity, bit 0 low byte, bit 1 high byte
   input wire logic [1:0] aSideParityPinsIn,
   output logic [1:0] aSideParityPinsOut,
   output logic aSideParityPinsOe,
   // B port data
   input wire logic [15:0] bPortDataIn,
   output logic [15:0] bPortDataOut,
   output logic bPortDataOe,
   // B port parity
   input wire logic [1:0] bSideParityPinsIn,
   output logic [1:0] bSideParityPinsOut,
   output logic bSideParityPinsOe,
   // Open-drain error flags
   input wire logic aSideParityErrorNIn,
   output logic aSideParityErrorNOut,
   output logic aSideParityErrorNOe,
   input wire logic bSideParityErrorNIn,
   output logic bSideParityErrorNOut,
   output logic bSideParityErrorNOe,
   // AXI4-Lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt
   output logic irq
);

   localparam int PIN_W = 2 * RTP_DATA_W + 2 * RTP_LANES + 10;
   // Enables and flag lines reset released so nothing drives early
   localparam logic [PIN_W-1:0] PIN_RST =
      {4'hF, {(PIN_W - 4){1'b0}}};

   function automatic logic [1:0] lanePar(input logic [15:0] d);
      logic [1:0] p;
      p = 2'h0;
      for (int i = 0; i < RTP_LANES; i++) begin
         p[i] = ^d[i*RTP_BYTE_W +: RTP_BYTE_W];
      end
      return p;
   endfunction

   function automatic logic [1:0] laneErr(input logic [15:0] d,
         input logic [1:0] p, input logic sense);
      return lanePar(d) ^ p ^ {2{sense}};
   endfunction

   // Pin synchronisers
   logic [PIN_W-1:0] pinRaw, pinMeta_r, pinSync_r;

   assign pinRaw = {aToBOutputEnableN, bToAOutputEnableN,
      aSideParityErrorNIn, bSideParityErrorNIn,
      aToBLatchEnable, aToBClock, generateOrCheckSelect,
      bToALatchEnable, bToAClock, paritySenseSelect,
      aSideParityPinsIn, bSideParityPinsIn, aPortDataIn, bPortDataIn};

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pinMeta_r <= PIN_RST;
         pinSync_r <= PIN_RST;
      end else if (ce) begin
         pinMeta_r <= pinRaw;
         pinSync_r <= pinMeta_r;
      end
   end

   logic sOeAbN, sOeBaN, sLineA, sLineB, sLeAb, sClkAb, sGenSel;
   logic sLeBa, sClkBa, sSense;
   logic [1:0] sAPar, sBPar;
   logic [15:0] sAData, sBData;

   assign {sOeAbN, sOeBaN, sLineA, sLineB, sLeAb, sClkAb, sGenSel,
      sLeBa, sClkBa, sSense, sAPar, sBPar, sAData, sBData} = pinSync_r;

   logic generating;
   assign generating = (sGenSel == RTP_SEL_GENERATE);

   // Transfer clock edge detection
   logic clkAbPrev_r, clkBaPrev_r;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         clkAbPrev_r <= 1'b0;
         clkBaPrev_r <= 1'b0;
      end else if (ce) begin
         clkAbPrev_r <= sClkAb;
         clkBaPrev_r <= sClkBa;
      end
   end

   logic abLoad, baLoad;
   // Transparent while latch enable high, else load on rising clock
   assign abLoad = sLeAb | (sClkAb & ~clkAbPrev_r);
   assign baLoad = sLeBa | (sClkBa & ~clkBaPrev_r);

   // Data stores; they run regardless of the output enables
   logic [15:0] abData_r, baData_r;
   logic [1:0] abPar_r, baPar_r;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         abData_r <= 16'h0000;
         abPar_r <= 2'h0;
      end else if (ce && abLoad) begin
         abData_r <= sAData;
         // Parity inputs are not looked at while generating
         abPar_r <= generating ? 2'h0 : sAPar;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         baData_r <= 16'h0000;
         baPar_r <= 2'h0;
      end else if (ce && baLoad) begin
         baData_r <= sBData;
         baPar_r <= sBPar;
      end
   end

   // Error conditions per direction
   logic abErrNow, baErrNow;
   assign abErrNow = !sOeAbN && !generating
      && (|laneErr(abData_r, abPar_r, sSense));
   assign baErrNow = !sOeBaN
      && (|laneErr(baData_r, baPar_r, sSense));

   // B side pin drivers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         bPortDataOut <= 16'h0000;
         bSideParityPinsOut <= 2'h0;
         bPortDataOe <= 1'b1;
         bSideParityPinsOe <= 1'b1;
      end else if (ce) begin
         bPortDataOut <= abData_r;
         if (generating) begin
            bSideParityPinsOut <= lanePar(abData_r) ^ {2{sSense}};
         end else begin
            bSideParityPinsOut <= abPar_r;
         end
         bPortDataOe <= sOeAbN;
         bSideParityPinsOe <= sOeAbN;
      end
   end

   // A side pin drivers; this direction never generates
   always_ff @(posedge clk) begin
      if (!resetn) begin
         aPortDataOut <= 16'h0000;
         aSideParityPinsOut <= 2'h0;
         aPortDataOe <= 1'b1;
         aSideParityPinsOe <= 1'b1;
      end else if (ce) begin
         aPortDataOut <= baData_r;
         aSideParityPinsOut <= baPar_r;
         aPortDataOe <= sOeBaN;
         aSideParityPinsOe <= sOeBaN;
      end
   end

   // Open-drain flags: only ever pull low, released otherwise
   always_ff @(posedge clk) begin
      if (!resetn) begin
         aSideParityErrorNOut <= 1'b0;
         bSideParityErrorNOut <= 1'b0;
         aSideParityErrorNOe <= 1'b1;
         bSideParityErrorNOe <= 1'b1;
      end else if (ce) begin
         aSideParityErrorNOut <= 1'b0;
         bSideParityErrorNOut <= 1'b0;
         aSideParityErrorNOe <= ~baErrNow;
         bSideParityErrorNOe <= ~abErrNow;
      end
   end

   // Error events for the register file
   logic abErrPrev_r, baErrPrev_r;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         abErrPrev_r <= 1'b0;
         baErrPrev_r <= 1'b0;
      end else if (ce) begin
         abErrPrev_r <= abErrNow;
         baErrPrev_r <= baErrNow;
      end
   end

   logic [RTP_EV_W-1:0] evSet;
   always_comb begin
      evSet = '0;
      evSet[RTP_EV_A_ERR] = baErrNow & ~baErrPrev_r;
      evSet[RTP_EV_B_ERR] = abErrNow & ~abErrPrev_r;
   end

   // AXI4-Lite write channel
   logic [3:0] wrAddr_r;
   logic [31:0] wrData_r;
   logic [3:0] wrStrb_r;
   logic wrFire;

   // Both halves held and no answer pending yet
   assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_axi_awready <= 1'b1;
         wrAddr_r <= 4'h0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            wrAddr_r <= s_axi_awaddr;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_axi_wready <= 1'b1;
         wrData_r <= 32'h00000000;
         wrStrb_r <= 4'h0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wrData_r <= s_axi_wdata;
            wrStrb_r <= s_axi_wstrb;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   logic wrMapped;
   always_comb begin
      if (wrAddr_r == RTP_OFFS_STATUS || wrAddr_r == RTP_OFFS_MASK
         || wrAddr_r == RTP_OFFS_LIVE) begin
         wrMapped = 1'b1;
      end else begin
         wrMapped = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RTP_RESP_OKAY;
      end else if (ce) begin
         if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? RTP_RESP_OKAY : RTP_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Status and mask
   logic [RTP_EV_W-1:0] status_r;
   logic [RTP_EV_W-1:0] status_nxt;
   logic [RTP_EV_W-1:0] mask_r;
   logic [RTP_EV_W-1:0] evClr;
   logic byte0Wr;

   assign byte0Wr = wrFire && wrStrb_r[0];

   always_comb begin
      evClr = '0;
      if (byte0Wr && wrAddr_r == RTP_OFFS_STATUS) begin
         evClr = wrData_r[RTP_EV_W-1:0];
      end
      // A new event wins over a clear in the same cycle
      status_nxt = (status_r & ~evClr) | evSet;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         status_r <= RTP_STATUS_RST;
      end else if (ce) begin
         status_r <= status_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mask_r <= RTP_MASK_RST;
      end else if (ce && byte0Wr && wrAddr_r == RTP_OFFS_MASK) begin
         mask_r <= wrData_r[RTP_EV_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(status_nxt & mask_r);
      end
   end

   // Live state view
   logic [RTP_LIVE_W-1:0] live;
   always_comb begin
      live = '0;
      live[RTP_LIVE_A_ERR] = baErrNow;
      live[RTP_LIVE_B_ERR] = abErrNow;
      live[RTP_LIVE_A_LINE] = sLineA;
      live[RTP_LIVE_B_LINE] = sLineB;
      live[RTP_LIVE_GEN] = generating;
   end

   // AXI4-Lite read channel
   logic [31:0] rdWord;
   logic [1:0] rdResp;
   always_comb begin
      rdWord = 32'h00000000;
      rdResp = RTP_RESP_OKAY;
      if (s_axi_araddr == RTP_OFFS_STATUS) begin
         rdWord[RTP_EV_W-1:0] = status_r;
      end else if (s_axi_araddr == RTP_OFFS_MASK) begin
         rdWord[RTP_EV_W-1:0] = mask_r;
      end else if (s_axi_araddr == RTP_OFFS_LIVE) begin
         rdWord[RTP_LIVE_W-1:0] = live;
      end else begin
         rdResp = RTP_RESP_SLVERR;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RTP_RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdResp;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// >>> include/rtp_pkg.sv
/*
 Constants shared by the registered parity transceiver: widths, register
 offsets, field positions, reset values and bus response codes.
 Assumes a single clock domain and an AXI4-Lite register bus.
*/
// Notes on behaviour
// - A-to-B enable high floats B data and parity; low drives them.
// - Each direction has a level latch feeding an edge-triggered store.
// - Latch enable high: transparent; low: clock rising edge captures input.
// - Latch enable low with steady clock holds the previous output.
// - B-to-A path mirrors A-to-B with its own enable, latch and clock.
// - Bits 0-7 pair with low parity bit, bits 8-15 with high one.
// - Check mode: odd count errs with sense low, even with sense high.
// - Generate mode: parity high for odd count/sense low or even/high.
// - Each direction's flag pulls low if either byte errs, else releases.
// - Check mode passes incoming parity bits unchanged with their byte.
// - Generate/check select affects A-to-B only; B-to-A always checks.
// - One parity sense select serves both directions; rest independent.
// - While generating, the B-direction error flag stays released.
// - While generating, A-side parity inputs are ignored; still outputs.
// - An error flag is active only while its direction's enable is on.
// - B-to-A parity errors show on the A flag, never the B flag.
// - Data pins are inputs one way and three-state outputs the other.
package rtp_pkg;
   localparam int RTP_DATA_W = 16;
   localparam int RTP_BYTE_W = 8;
   localparam int RTP_LANES = 2;
   localparam int RTP_ADDR_W = 4;

   // Register offsets (byte addresses)
   localparam logic [3:0] RTP_OFFS_STATUS = 4'h0;
   localparam logic [3:0] RTP_OFFS_MASK = 4'h4;
   localparam logic [3:0] RTP_OFFS_LIVE = 4'h8;

   // Status and mask fields
   localparam int RTP_EV_A_ERR = 0;
   localparam int RTP_EV_B_ERR = 1;
   localparam int RTP_EV_W = 2;
   localparam logic [1:0] RTP_STATUS_RST = 2'h0;
   localparam logic [1:0] RTP_MASK_RST = 2'h0;

   // Live state fields
   localparam int RTP_LIVE_A_ERR = 0;
   localparam int RTP_LIVE_B_ERR = 1;
   localparam int RTP_LIVE_A_LINE = 2;
   localparam int RTP_LIVE_B_LINE = 3;
   localparam int RTP_LIVE_GEN = 4;
   localparam int RTP_LIVE_W = 5;

   // Mode select level meaning generate
   localparam logic RTP_SEL_GENERATE = 1'b0;

   localparam logic [1:0] RTP_RESP_OKAY = 2'h0;
   localparam logic [1:0] RTP_RESP_SLVERR = 2'h2;
endpackage

// >>> test/rtp_transceiver_asserts.sv
/*
 Concurrent checks on the pin behaviour of the parity transceiver.
 Assumes it is bound to the top module by port name, one clock domain.
*/
`timescale 1ns/1ns
module rtp_checker
   import rtp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Controls
   input wire logic aToBOutputEnableN,
   input wire logic aToBLatchEnable,
   input wire logic aToBClock,
   input wire logic generateOrCheckSelect,
   input wire logic bToAOutputEnableN,
   input wire logic bToALatchEnable,
   input wire logic paritySenseSelect,
   // A side pins
   input wire logic [15:0] aPortDataIn,
   input wire logic aPortDataOe,
   input wire logic [1:0] aSideParityPinsIn,
   input wire logic aSideParityPinsOe,
   input wire logic aSideParityErrorNOe,
   // B side pins
   input wire logic [15:0] bPortDataIn,
   input wire logic [15:0] bPortDataOut,
   input wire logic bPortDataOe,
   input wire logic [1:0] bSideParityPinsIn,
   input wire logic [1:0] bSideParityPinsOut,
   input wire logic bSideParityPinsOe,
   input wire logic bSideParityErrorNOe
);
   logic [1:0] genPar;
   logic errBA;
   assign genPar = {^aPortDataIn[15:8], ^aPortDataIn[7:0]}
      ^ {2{paritySenseSelect}};
   assign errBA = |({^bPortDataIn[15:8], ^bPortDataIn[7:0]}
      ^ bSideParityPinsIn ^ {2{paritySenseSelect}});
   default clocking @(posedge clk); endclocking
   // Frozen cycles stall the pipeline, so they are not judged
   default disable iff (!resetn || !ce);
   // Data must stay put around the edge, or the capture is ambiguous
   sequence s_quiet_a;
      (!aToBLatchEnable && $stable(aPortDataIn))[*3];
   endsequence
   sequence s_capture_a;
      s_quiet_a ##1 (!aToBLatchEnable && $stable(aPortDataIn)
         && $rose(aToBClock)) ##1 s_quiet_a;
   endsequence
   chk_b_float: assert property (
      aToBOutputEnableN[*6] |-> bPortDataOe && bSideParityPinsOe
         && bSideParityErrorNOe)
      else $error("B side driven while disabled");
   chk_a_float: assert property (
      bToAOutputEnableN[*6] |-> aPortDataOe && aSideParityPinsOe
         && aSideParityErrorNOe)
      else $error("A side driven while disabled");
   chk_b_follow: assert property (
      (aToBLatchEnable && $stable(aPortDataIn))[*6]
         |-> bPortDataOut == aPortDataIn)
      else $error("B data not transparent");
   chk_gen_parity: assert property (
      ($stable({aPortDataIn, paritySenseSelect}) && aToBLatchEnable
         && generateOrCheckSelect == RTP_SEL_GENERATE)[*6]
         |-> bSideParityPinsOut == genPar)
      else $error("Generated parity wrong");
   chk_check_pass: assert property (
      (aToBLatchEnable && generateOrCheckSelect != RTP_SEL_GENERATE
         && $stable(aSideParityPinsIn))[*6]
         |-> bSideParityPinsOut == aSideParityPinsIn)
      else $error("Parity not passed through");
   chk_gen_flag_free: assert property (
      (generateOrCheckSelect == RTP_SEL_GENERATE)[*6]
         |-> bSideParityErrorNOe)
      else $error("B flag pulled while generating");
   chk_a_flag_err: assert property (
      (bToALatchEnable && !bToAOutputEnableN && $stable({bPortDataIn,
         bSideParityPinsIn, paritySenseSelect}))[*6]
         |-> aSideParityErrorNOe == !errBA)
      else $error("A flag disagrees with parity");
   chk_b_capture: assert property (
      s_capture_a |-> ##2 bPortDataOut == $past(aPortDataIn, 5))
      else $error("Clock edge did not capture");
endmodule

bind rtp_transceiver rtp_checker u_rtp_checker (.*);

// >>> test/rtp_far_side.sv
/*
 Far-side model: the A and B logic buses and the error flag pull-ups.
 Assumes the bench picks what each bus offers while the device is off.
*/
`timescale 1ns/1ns
module rtp_far_side (
   // Values the far-side drivers offer
   input wire logic [15:0] aVal,
   input wire logic [1:0] aPar,
   input wire logic [15:0] bVal,
   input wire logic [1:0] bPar,
   // Device drive
   input wire logic [15:0] aOut,
   input wire logic [1:0] aParOut,
   input wire logic aOe,
   input wire logic aPOe,
   input wire logic [15:0] bOut,
   input wire logic [1:0] bParOut,
   input wire logic bOe,
   input wire logic bPOe,
   input wire logic aEOe,
   input wire logic bEOe,
   // Resolved wire levels
   output logic [15:0] aIn,
   output logic [1:0] aParIn,
   output logic [15:0] bIn,
   output logic [1:0] bParIn,
   output logic aEIn,
   output logic bEIn
);
   // The far side backs off whenever the device drives
   assign aIn = aOe ? aVal : aOut;
   assign aParIn = aPOe ? aPar : aParOut;
   assign bIn = bOe ? bVal : bOut;
   assign bParIn = bPOe ? bPar : bParOut;
   // Pull-up wins only while the open drain lets go
   assign aEIn = aEOe;
   assign bEIn = bEOe;
endmodule

// >>> test/registered_transceiver_with_byte_parity_bench.sv
/*
 Self-checking bench for the registered parity transceiver.
 Assumes the far-side model and the bound checker; 20 MHz clock.
*/
`timescale 1ns/1ns
module registered_transceiver_with_byte_parity_bench;
   import rtp_pkg::*;
   logic clk = 0, resetn = 0, ce = 1, a_to_b_output_enable_n = 1, a_to_b_latch_enable = 1, ckAB = 0;
   logic gen = 1, b_to_a_output_enable_n = 1, b_to_a_latch_enable = 1, ckBA = 0, sense = 0, irq;
   logic aOe, bOe, aPOe, bPOe, aEOut, aEOe, bEOut, bEOe, aEIn, bEIn;
   logic [15:0] aVal = 0, bVal = 0, aIn, bIn, aOut, bOut;
   logic [1:0] aPar = 0, bPar = 0, aParIn, bParIn, aParOut, bParOut;
   logic [3:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [33:0] expq[$];
   int failures = 0, nChecks = 0, seed = 87483, i;
   rtp_transceiver u_rtp_transceiver (.clk(clk), .resetn(resetn), .ce(ce),
      .aToBOutputEnableN(a_to_b_output_enable_n), .aToBLatchEnable(a_to_b_latch_enable), .aToBClock(ckAB),
      .generateOrCheckSelect(gen), .bToAOutputEnableN(b_to_a_output_enable_n),
      .bToALatchEnable(b_to_a_latch_enable), .bToAClock(ckBA), .paritySenseSelect(sense),
      .aPortDataIn(aIn), .aPortDataOut(aOut), .aPortDataOe(aOe),
      .aSideParityPinsIn(aParIn), .aSideParityPinsOut(aParOut),
      .aSideParityPinsOe(aPOe), .bPortDataIn(bIn), .bPortDataOut(bOut),
      .bPortDataOe(bOe), .bSideParityPinsIn(bParIn),
      .bSideParityPinsOut(bParOut), .bSideParityPinsOe(bPOe),
      .aSideParityErrorNIn(aEIn), .aSideParityErrorNOut(aEOut),
      .aSideParityErrorNOe(aEOe), .bSideParityErrorNIn(bEIn),
      .bSideParityErrorNOut(bEOut), .bSideParityErrorNOe(bEOe),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(irq));
   rtp_far_side u_rtp_far_side (.aVal(aVal), .aPar(aPar), .bVal(bVal),
      .bPar(bPar), .aOut(aOut), .aParOut(aParOut), .aOe(aOe), .aPOe(aPOe),
      .bOut(bOut), .bParOut(bParOut), .bOe(bOe), .bPOe(bPOe), .aEOe(aEOe),
      .bEOe(bEOe), .aIn(aIn), .aParIn(aParIn), .bIn(bIn), .bParIn(bParIn),
      .aEIn(aEIn), .bEIn(bEIn));
   initial forever #25 clk = ~clk;
   function automatic logic [1:0] pgen(input logic [15:0] d, input logic s);
      return {^d[15:8], ^d[7:0]} ^ {s, s};
   endfunction
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      nChecks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d failures %0d", nChecks, failures);
      if (failures == 0 && nChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Pins pass two sync stages before the store, so allow for the lag
   task settle;
      repeat (7) @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] ad, input logic [31:0] d,
      input logic [1:0] r);
      expq.push_back({r, 32'h0});
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid) bready <= 1'b0;
      end while (awvalid || wvalid || bready);
   endtask
   task automatic rd(input logic [3:0] ad, input logic [33:0] e);
      expq.push_back(e);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid) rready <= 1'b0;
      end while (arvalid || rready);
   endtask
   always @(posedge clk) begin
      if (bvalid && bready)
         chk({bresp, 32'h0}, expq.pop_front());
      if (rvalid && rready)
         chk({rresp, rdata}, expq.pop_front());
   end
   initial begin
      repeat (4000) @(posedge clk);
      failures++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(RTP_OFFS_MASK, {RTP_RESP_OKAY, 32'h0});
      a_to_b_output_enable_n <= 1'b0;
      for (i = 0; i < 16; i++) begin
         {gen, sense} <= i[1:0];
         aVal <= 16'($random(seed));
         aPar <= 2'($random(seed));
         settle();
         chk(34'(bOut), 34'(aVal));
         chk(34'(bOe), 34'h0);
         if (gen == RTP_SEL_GENERATE) begin
            chk(34'(bParOut), 34'(pgen(aVal, sense)));
            chk(34'(bEIn), 34'h1);
         end else begin
            chk(34'(bParOut), 34'(aPar));
            chk(34'(bEIn), 34'(~|(pgen(aVal, sense) ^ aPar)));
         end
      end
      a_to_b_output_enable_n <= 1'b1;
      b_to_a_output_enable_n <= 1'b0;
      // Let both ports turn round before the first value is judged
      settle();
      for (i = 0; i < 8; i++) begin
         {gen, sense} <= i[1:0];
         bVal <= 16'($random(seed));
         bPar <= 2'($random(seed));
         settle();
         chk(34'(aOut), 34'(bVal));
         chk(34'(aParOut), 34'(bPar));
         chk(34'(aEIn), 34'(~|(pgen(bVal, sense) ^ bPar)));
         chk(34'(bEIn), 34'h1);
         chk(34'(bOe), 34'h1);
         chk(34'({aEOut, bEOut, aOe}), 34'h0);
      end
      gen <= 1'b1;
      sense <= 1'b0;
      bPar <= pgen(bVal, 1'b0);
      settle();
      wr(RTP_OFFS_STATUS, 32'h3, RTP_RESP_OKAY);
      rd(RTP_OFFS_STATUS, {RTP_RESP_OKAY, 32'h0});
      bPar <= ~pgen(bVal, 1'b0);
      settle();
      rd(RTP_OFFS_LIVE, {RTP_RESP_OKAY, 32'h9});
      rd(RTP_OFFS_STATUS, {RTP_RESP_OKAY, 32'h1});
      wr(RTP_OFFS_MASK, 32'h1, RTP_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(34'(irq), 34'h1);
      wr(RTP_OFFS_MASK, 32'h2, RTP_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(34'(irq), 34'h0);
      wr(RTP_OFFS_STATUS, 32'h1, RTP_RESP_OKAY);
      rd(RTP_OFFS_STATUS, {RTP_RESP_OKAY, 32'h0});
      wr(4'hC, 32'h1, RTP_RESP_SLVERR);
      rd(4'hC, {RTP_RESP_SLVERR, 32'h0});
      // Clocked flow, loaded while the outputs are still off
      b_to_a_output_enable_n <= 1'b1;
      a_to_b_latch_enable <= 1'b0;
      aVal <= 16'hA5C3;
      settle();
      ckAB <= 1'b1;
      settle();
      ckAB <= 1'b0;
      a_to_b_output_enable_n <= 1'b0;
      settle();
      chk(34'(bOut), 34'hA5C3);
      aVal <= 16'h3C5A;
      settle();
      chk(34'(bOut), 34'hA5C3);
      ckAB <= 1'b1;
      settle();
      chk(34'(bOut), 34'h3C5A);
      // Clock enable low freezes even a transparent path
      a_to_b_latch_enable <= 1'b1;
      ce <= 1'b0;
      aVal <= 16'h0F0F;
      settle();
      chk(34'(bOut), 34'h3C5A);
      ce <= 1'b1;
      settle();
      chk(34'(bOut), 34'h0F0F);
      end_sim();
   end
endmodule
